// [pmwc_pkg.sv]
// Package: constants for power mode and wake control
package pmwc_pkg;

  // ********************************
  // Power mode field encodings
  // ********************************
  localparam int          PMWC_MODE_MSB   = 4;
  localparam int          PMWC_MODE_LSB   = 3;
  localparam logic [1:0]  PMWC_MODE_NORM  = 2'h0;
  localparam logic [1:0]  PMWC_MODE_ENERGY_DETECT_POWER_DOWN  = 2'h1;
  localparam logic [1:0]  PMWC_MODE_SOFT  = 2'h2;

  // ********************************
  // Timing
  // ********************************
  localparam int          PMWC_CLK_HZ     = 20000000;
  localparam int          PMWC_CLK_PS     = 50000;
  localparam int          PMWC_WAKE_NS    = 100;
  // Energy must persist longer than 100 ns: strictly more cycles
  localparam int          PMWC_WAKE_CYC   = (PMWC_WAKE_NS * 1000) / PMWC_CLK_PS + 1;
  localparam int          PMWC_PULSE_CYC  = 1;
  localparam int          PMWC_STRAP_W    = 8;

  // ********************************
  // Wake packet pattern
  // ********************************
  localparam logic [7:0]  PMWC_SYNC_BYTE  = 8'hFF;
  localparam int          PMWC_SYNC_CNT   = 6;
  localparam int          PMWC_MAC_REPS   = 16;
  localparam int          PMWC_MAC_BYTES  = 6;

  // Global operating states of the sequencer
  typedef enum logic [1:0] {
    PMWC_ST_NORM = 2'h0,
    PMWC_ST_EDHI = 2'h1,
    PMWC_ST_EDLO = 2'h3,
    PMWC_ST_SOFT = 2'h2
  } pmwc_state_t;

endpackage

// [pmwc_wake_match.sv]
// Wake packet byte-stream matcher
`timescale 1ns/1ps
module pmwc_wake_match
  import pmwc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  // Control
  input  wire logic        enable,
  input  wire logic [47:0] node_mac,
  // Receive byte stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_eof,
  // Result
  output logic             found
);

  logic [2:0] sync_r, sync_nxt;
  logic [6:0] mpos_r, mpos_nxt;
  logic       found_r, found_nxt;
  logic [7:0] exp_byte;
  logic [2:0] bidx;

  // Expected address byte, first byte on wire is bits [47:40]
  always_comb begin
    bidx     = 3'(mpos_r % PMWC_MAC_BYTES);
    exp_byte = node_mac[8'(47 - 8 * bidx) -: 8];
  end

  // Search state next values
  always_comb begin
    sync_nxt  = sync_r;
    mpos_nxt  = mpos_r;
    found_nxt = 1'b0;
    if (!enable || rx_eof) begin
      sync_nxt = 3'h0;
      mpos_nxt = 7'h00;
    end else if (rx_valid) begin
      if (sync_r < 3'(PMWC_SYNC_CNT)) begin
        sync_nxt = (rx_byte == PMWC_SYNC_BYTE) ? sync_r + 3'h1 : 3'h0;
      end else if (rx_byte == exp_byte) begin
        if (mpos_r == 7'(PMWC_MAC_REPS * PMWC_MAC_BYTES - 1)) begin
          found_nxt = 1'b1;
          sync_nxt  = 3'h0;
          mpos_nxt  = 7'h00;
        end else begin
          mpos_nxt = mpos_r + 7'h01;
        end
      end else if (mpos_r == 7'h00 && rx_byte == PMWC_SYNC_BYTE) begin
        sync_nxt = sync_r;                           // Longer FF run keeps sync
      end else begin
        // Restart; a FF byte may begin a new sync run
        sync_nxt = (rx_byte == PMWC_SYNC_BYTE) ? 3'h1 : 3'h0;
        mpos_nxt = 7'h00;
      end
    end
  end

  // Search state registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync_r  <= 3'h0;
      mpos_r  <= 7'h00;
      found_r <= 1'b0;
    end else if (clk_en) begin
      sync_r  <= sync_nxt;
      mpos_r  <= mpos_nxt;
      found_r <= found_nxt;
    end
  end

  assign found = found_r;

endmodule

// [pmwc_top.sv]
// Power mode sequencer and wake event reporting
// ********************************
// ********************************
`timescale 1ns/1ps
module pmwc_top
  import pmwc_pkg::*;
#(
  parameter int NPORT     = 5,
  parameter int TOUT_W    = 24,
  parameter int PULSE_PER = 32768
)(
  // Clock, reset, enable
  input  wire logic                    mclk,
  input  wire logic                    arst_n,
  input  wire logic                    clk_en,
  // Power control field and settings
  input  wire logic [4:0]              pwr_ctrl,
  input  wire logic                    pwr_ctrl_we,
  input  wire logic [NPORT-1:0]        port_pd,
  input  wire logic [TOUT_W-1:0]       idle_timeout,
  input  wire logic [PMWC_STRAP_W-1:0] strap_in,
  // Wake event enables and routing
  input  wire logic                    wake_energy_en,
  input  wire logic                    wake_link_en,
  input  wire logic                    wake_pkt_en,
  input  wire logic                    wake_to_irq,
  input  wire logic                    wake_clear,
  input  wire logic [47:0]             node_mac,
  // Cable side indications
  input  wire logic [NPORT-1:0]        cable_energy,
  input  wire logic [NPORT-1:0]        link_up,
  // Receive byte stream of frames for the node or broadcast
  input  wire logic                    rx_valid,
  input  wire logic [7:0]              rx_byte,
  input  wire logic                    rx_eof,
  input  wire logic                    rx_for_node,
  // Block enables
  output logic                         pll_en,
  output logic [NPORT-1:0]             phy_en,
  output logic [NPORT-1:0]             phy_ed_only,
  output logic [NPORT-1:0]             mac_en,
  output logic                         host_if_en,
  output logic                         smi_en,
  output logic                         link_pulse,
  output logic                         regs_reset,
  output logic [PMWC_STRAP_W-1:0]      strap_cfg,
  output logic [1:0]                   mode_sel,
  // Wake status and host signalling
  output logic [2:0]                   wake_status,
  output logic                         power_event_out_n,
  output logic                         interrupt_out_n
);

  localparam int PW = $clog2(PULSE_PER);

  // ********************************
  // Decode helpers
  // ********************************
  // Mode code is one of the three defined global modes
  function automatic logic mode_valid(input logic [1:0] m);
    return m inside {PMWC_MODE_NORM, PMWC_MODE_ENERGY_DETECT_POWER_DOWN, PMWC_MODE_SOFT};
  endfunction

  // Low-power state: only receive energy detection and the periodic link pulse run
  function automatic logic in_low_power(input pmwc_state_t s);
    return s == PMWC_ST_EDLO;
  endfunction

  // ********************************
  // Mode sequencer
  // ********************************
  pmwc_state_t             st_r, st_nxt;
  logic [1:0]              mode_r, mode_nxt;
  logic [TOUT_W-1:0]       idle_r, idle_nxt;
  logic [3:0]              wake_r, wake_nxt;
  logic [PW-1:0]           pcnt_r, pcnt_nxt;
  logic                    any_energy;
  logic [1:0]              wr_mode;

  assign any_energy = |cable_energy;
  assign wr_mode    = pwr_ctrl[PMWC_MODE_MSB:PMWC_MODE_LSB];

  // Next mode and state
  always_comb begin
    st_nxt   = st_r;
    mode_nxt = mode_r;
    idle_nxt = idle_r;
    wake_nxt = wake_r;
    pcnt_nxt = pcnt_r;
    // Code 11 ignored; in low-power a write only updates the stored field
    if (pwr_ctrl_we && mode_valid(wr_mode)) begin
      mode_nxt = wr_mode;                                // Stored mode field
    end
    unique case (st_r)
      PMWC_ST_NORM: begin
        if (pwr_ctrl_we && wr_mode == PMWC_MODE_ENERGY_DETECT_POWER_DOWN) begin
          st_nxt   = PMWC_ST_EDHI;
          idle_nxt = '0;
        end else if (pwr_ctrl_we && wr_mode == PMWC_MODE_SOFT) begin
          st_nxt = PMWC_ST_SOFT;
        end
      end
      PMWC_ST_EDHI: begin
        if (pwr_ctrl_we && wr_mode == PMWC_MODE_NORM) begin
          st_nxt = PMWC_ST_NORM;
        end else if (pwr_ctrl_we && wr_mode == PMWC_MODE_SOFT) begin
          st_nxt = PMWC_ST_SOFT;
        end else if (any_energy) begin
          idle_nxt = '0;
        end else if (idle_r >= idle_timeout) begin
          st_nxt   = PMWC_ST_EDLO;
          wake_nxt = 4'h0;
          pcnt_nxt = '0;
        end else begin
          idle_nxt = idle_r + 1'b1;
        end
      end
      PMWC_ST_EDLO: begin
        // Host interface is down; only energy can bring us back
        pcnt_nxt = (pcnt_r == PW'(PULSE_PER - 1)) ? '0 : pcnt_r + 1'b1;
        // Energy must persist several samples; a gap restarts the count
        if (any_energy) begin
          if (wake_r >= 4'(PMWC_WAKE_CYC - 1)) begin
            st_nxt   = PMWC_ST_EDHI;
            idle_nxt = '0;
          end else begin
            wake_nxt = wake_r + 4'h1;
          end
        end else begin
          wake_nxt = 4'h0;
        end
      end
      PMWC_ST_SOFT: begin
        // Any defined code other than soft-down leaves through normal
        if (pwr_ctrl_we && wr_mode != PMWC_MODE_SOFT && mode_valid(wr_mode)) begin
          st_nxt   = PMWC_ST_NORM;
          mode_nxt = PMWC_MODE_NORM;                     // Registers back to default
        end
      end
    endcase
  end

  // Mode registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r   <= PMWC_ST_NORM;
      mode_r <= PMWC_MODE_NORM;
      idle_r <= '0;
      wake_r <= 4'h0;
      pcnt_r <= '0;
    end else if (clk_en) begin
      st_r   <= st_nxt;
      mode_r <= mode_nxt;
      idle_r <= idle_nxt;
      wake_r <= wake_nxt;
      pcnt_r <= pcnt_nxt;
    end
  end

  // ********************************
  // Block enables and strap capture
  // ********************************
  logic [NPORT-1:0]        phy_en_nxt, ed_nxt;
  logic                    pll_nxt, host_nxt, lp_nxt, rst_nxt, strap_take;
  logic                    smi_nxt;
  logic [PMWC_STRAP_W-1:0] strap_nxt;
  logic                    strap_pend_r, strap_pend_nxt;

  // Enables decoded from the next state
  always_comb begin
    pll_nxt    = 1'b0;
    host_nxt   = 1'b0;
    phy_en_nxt = '0;
    ed_nxt     = '0;
    unique case (st_nxt)
      PMWC_ST_NORM, PMWC_ST_EDHI: begin
        pll_nxt    = 1'b1;
        host_nxt   = 1'b1;
        phy_en_nxt = ~port_pd;
      end
      PMWC_ST_EDLO: begin
        ed_nxt = ~port_pd;
      end
      PMWC_ST_SOFT: begin
        // Soft-down: everything off but serial management
        phy_en_nxt = '0;
      end
    endcase
    // Serial management stays up except in the low-power state
    smi_nxt        = !in_low_power(st_nxt);
    lp_nxt         = in_low_power(st_r) && in_low_power(st_nxt) &&
                     (pcnt_r < PW'(PMWC_PULSE_CYC));
    rst_nxt        = (st_r == PMWC_ST_SOFT) && (st_nxt != PMWC_ST_SOFT);
    strap_pend_nxt = rst_nxt;
    // Straps caught a cycle after reset release and after soft-down exit
    strap_take = strap_pend_r;
    strap_nxt  = strap_take ? strap_in : strap_cfg;
  end

  // Enable registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pll_en       <= 1'b1;
      host_if_en   <= 1'b1;
      smi_en       <= 1'b1;
      phy_en       <= '0;
      phy_ed_only  <= '0;
      mac_en       <= '0;
      link_pulse   <= 1'b0;
      regs_reset   <= 1'b0;
      strap_pend_r <= 1'b1;
      strap_cfg    <= '0;
      mode_sel     <= PMWC_MODE_NORM;
    end else if (clk_en) begin
      pll_en       <= pll_nxt;
      host_if_en   <= host_nxt;
      smi_en       <= smi_nxt;
      phy_en       <= phy_en_nxt;
      phy_ed_only  <= ed_nxt;
      mac_en       <= phy_en_nxt;
      link_pulse   <= lp_nxt;
      regs_reset   <= rst_nxt;
      strap_pend_r <= strap_pend_nxt;
      strap_cfg    <= strap_nxt;
      mode_sel     <= mode_nxt;
    end
  end

  // ********************************
  // Wake events and reporting
  // ********************************
  logic             pkt_found;
  logic [NPORT-1:0] link_d_r;
  logic [NPORT-1:0] link_d_nxt;
  logic [2:0]       ws_nxt;
  logic [2:0]       ev;
  logic             pkt_valid;
  logic             pe_n_nxt;
  logic             irq_n_nxt;

  // Only frames for the node or broadcast reach the matcher
  assign pkt_valid = rx_valid && rx_for_node;

  // Matcher state is dropped whenever packet wake is disabled
  pmwc_wake_match u_match (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .enable   (wake_pkt_en),
    .node_mac (node_mac),
    .rx_valid (pkt_valid),
    .rx_byte  (rx_byte),
    .rx_eof   (rx_eof),
    .found    (pkt_found)
  );

  // Sticky event flags, set wins over clear
  always_comb begin
    link_d_nxt = link_up;
    ev[0] = wake_energy_en && in_low_power(st_r) && (st_nxt == PMWC_ST_EDHI);
    ev[1] = wake_link_en && |(link_up & ~link_d_r);
    ev[2] = wake_pkt_en && pkt_found;
    // Clear drops old flags; an event in the same cycle still sets
    ws_nxt = (wake_clear ? 3'h0 : wake_status) | ev;
    // Event pins follow the next status, routed by wake_to_irq
    pe_n_nxt  = ~(|ws_nxt && !wake_to_irq);
    irq_n_nxt = ~(|ws_nxt && wake_to_irq);
  end

  // Event registers and active-low outputs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link_d_r          <= '0;
      wake_status       <= 3'h0;
      power_event_out_n <= 1'b1;
      interrupt_out_n   <= 1'b1;
    end else if (clk_en) begin
      link_d_r          <= link_d_nxt;
      wake_status       <= ws_nxt;
      power_event_out_n <= pe_n_nxt;
      interrupt_out_n   <= irq_n_nxt;
    end
  end

endmodule

// [pmwc_assertions.sv]
// Checker: port-level assertions for the power mode block
`timescale 1ns/1ps
module pmwc_chk
  import pmwc_pkg::*;
#(
  parameter int NPORT = 5
)(
  // Clock and reset
  input wire logic             mclk,
  input wire logic             arst_n,
  input wire logic             clk_en,
  // Inputs watched
  input wire logic [4:0]       pwr_ctrl,
  input wire logic             pwr_ctrl_we,
  input wire logic [NPORT-1:0] port_pd,
  input wire logic [NPORT-1:0] cable_energy,
  input wire logic [NPORT-1:0] link_up,
  input wire logic             wake_link_en,
  input wire logic             wake_to_irq,
  // Outputs watched
  input wire logic             pll_en,
  input wire logic [NPORT-1:0] phy_en,
  input wire logic [NPORT-1:0] phy_ed_only,
  input wire logic [NPORT-1:0] mac_en,
  input wire logic             host_if_en,
  input wire logic             smi_en,
  input wire logic             link_pulse,
  input wire logic             regs_reset,
  input wire logic [1:0]       mode_sel,
  input wire logic [2:0]       wake_status,
  input wire logic             power_event_out_n,
  input wire logic             interrupt_out_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ****
  // Mode changes
  // ****
  property p_norm;
    clk_en && pwr_ctrl_we && pwr_ctrl[4:3] == PMWC_MODE_NORM && smi_en
      |=> mode_sel == PMWC_MODE_NORM && pll_en && host_if_en;
  endproperty
  a_norm: assert property (p_norm) else $error("normal mode not entered");
  property p_energy_detect_power_down;
    clk_en && pwr_ctrl_we && pwr_ctrl[4:3] == PMWC_MODE_ENERGY_DETECT_POWER_DOWN && host_if_en
      |=> mode_sel == PMWC_MODE_ENERGY_DETECT_POWER_DOWN && pll_en;
  endproperty
  a_energy_detect_power_down: assert property (p_energy_detect_power_down) else $error("energy-detect mode not entered");
  property p_soft;
    clk_en && pwr_ctrl_we && pwr_ctrl[4:3] == PMWC_MODE_SOFT && host_if_en |=>
      smi_en && !pll_en && !host_if_en && mac_en == '0 && phy_en == '0;
  endproperty
  a_soft: assert property (p_soft) else $error("soft power-down wrong");
  property p_excl;
    mode_sel != 2'h3 && pll_en == host_if_en;
  endproperty
  a_excl: assert property (p_excl) else $error("mode state inconsistent");
  property p_exit;
    clk_en && pwr_ctrl_we && pwr_ctrl[4:3] != 2'h3 && pwr_ctrl[4:3] != PMWC_MODE_SOFT && smi_en && !host_if_en
      |=> regs_reset && pll_en ##1 !regs_reset;
  endproperty
  a_exit: assert property (p_exit) else $error("soft exit without one reset pulse");
  // ****
  // Port enables and low power
  // ****
  property p_port;
    pll_en && $past(pll_en) && $past(arst_n) |-> mac_en == ~$past(port_pd) && phy_en == ~$past(port_pd);
  endproperty
  a_port: assert property (p_port) else $error("port enables wrong");
  property p_low;
    !smi_en && !$past(smi_en) |-> phy_ed_only == ~$past(port_pd) && phy_en == '0 && mac_en == '0 && !pll_en;
  endproperty
  a_low: assert property (p_low) else $error("low-power enables wrong");
  property p_wake;
    (clk_en && !smi_en && |cable_energy) [*3] |-> ##[1:2] pll_en;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on energy");
  property p_pulse;
    link_pulse && clk_en |-> !smi_en ##1 !link_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("link pulse wrong");
  // ****
  // Wake reporting
  // ****
  property p_link;
    clk_en && wake_link_en && |(link_up & ~$past(link_up)) |=> wake_status[1];
  endproperty
  a_link: assert property (p_link) else $error("link wake missed");
  property p_route;
    $stable(wake_to_irq) |-> power_event_out_n == !(|wake_status && !wake_to_irq) &&
      interrupt_out_n == !(|wake_status && wake_to_irq);
  endproperty
  a_route: assert property (p_route) else $error("event output wrong");
  c_pkt: cover property ($rose(wake_status[2]));
  c_exit: cover property (regs_reset);
  c_pulse: cover property (link_pulse);
endmodule
bind pmwc_top pmwc_chk #(.NPORT(NPORT)) chk_u (.mclk, .arst_n, .clk_en, .pwr_ctrl, .pwr_ctrl_we, .port_pd,
  .cable_energy, .link_up, .wake_link_en, .wake_to_irq, .pll_en, .phy_en, .phy_ed_only, .mac_en,
  .host_if_en, .smi_en, .link_pulse, .regs_reset, .mode_sel, .wake_status, .power_event_out_n,
  .interrupt_out_n);

// [pmwc_link_model.sv]
// Link partner model: delivers frames as a byte stream
`timescale 1ns/1ps
module pmwc_link_model (
  // Clock
  input  wire logic mclk,
  // Byte stream toward the block
  output logic       rx_valid,
  output logic [7:0] rx_byte,
  output logic       rx_eof,
  output logic       rx_for_node
);
  // Idle stream at time zero
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_eof = 1'b0;
    rx_for_node = 1'b0;
  end
  // Send one frame; idle byte is the inverse of the last
  task automatic send_frame(input logic [7:0] b[$], input logic for_node);
    @(posedge mclk);
    #1;
    rx_for_node = for_node;
    foreach (b[i]) begin
      rx_valid = 1'b1;
      rx_byte = b[i];
      @(posedge mclk);
      #1;
    end
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
    rx_eof = 1'b1;
    @(posedge mclk);
    #1;
    rx_eof = 1'b0;
    rx_for_node = 1'b0;
  endtask
endmodule

// [testbench.sv]
// Testbench: random and corner-case checks of the power mode block
`timescale 1ns/1ps
module testbench
  import pmwc_pkg::*;
;
  localparam int NP  = 5;
  localparam int PER = 16;
  logic        mclk, arst_n, clk_en, pwr_ctrl_we, wake_energy_en, wake_link_en, wake_pkt_en, wake_to_irq;
  logic        wake_clear, rx_valid, rx_eof, rx_for_node, pll_en, host_if_en, smi_en, link_pulse, regs_reset;
  logic        power_event_out_n, interrupt_out_n;
  logic [4:0]  pwr_ctrl;
  logic [NP-1:0] port_pd, cable_energy, link_up, phy_en, phy_ed_only, mac_en;
  logic [23:0] idle_timeout;
  logic [7:0]  strap_in, strap_cfg, rx_byte;
  logic [47:0] node_mac;
  logic [1:0]  mode_sel;
  logic [2:0]  wake_status;
  logic [7:0]  q[$];
  int          n_mismatch = 0, checks_done = 0, cyc = 0, n;
  pmwc_top #(.NPORT(NP), .TOUT_W(24), .PULSE_PER(PER)) dut_u (.mclk, .arst_n, .clk_en, .pwr_ctrl,
    .pwr_ctrl_we, .port_pd, .idle_timeout, .strap_in, .wake_energy_en, .wake_link_en, .wake_pkt_en,
    .wake_to_irq, .wake_clear, .node_mac, .cable_energy, .link_up, .rx_valid, .rx_byte, .rx_eof,
    .rx_for_node, .pll_en, .phy_en, .phy_ed_only, .mac_en, .host_if_en, .smi_en, .link_pulse,
    .regs_reset, .strap_cfg, .mode_sel, .wake_status, .power_event_out_n, .interrupt_out_n);
  pmwc_link_model lp_u (.mclk, .rx_valid, .rx_byte, .rx_eof, .rx_for_node);
  // Clock generation
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ****
  // Helpers
  // ****
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [1:0] m);
    pwr_ctrl = {m, 3'($urandom)};
    pwr_ctrl_we = 1'b1;
    tick(1);
    pwr_ctrl_we = 1'b0;
    tick(1);
  endtask
  // Expected event pins {power event, interrupt}
  function automatic logic [1:0] exp_route(input logic any, input logic irq);
    return {!(any && !irq), !(any && irq)};
  endfunction
  // Sync bytes then address copies, first byte on the wire first
  function automatic void add(input int ffs, input int reps);
    repeat (ffs) q.push_back(PMWC_SYNC_BYTE);
    repeat (reps) for (int k = 5; k >= 0; k--) q.push_back(node_mac[8*k +: 8]);
  endfunction
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    {arst_n, pwr_ctrl_we, wake_energy_en, wake_link_en, wake_pkt_en, wake_to_irq, wake_clear} = '0;
    {pwr_ctrl, cable_energy, link_up, idle_timeout} = '0;
    clk_en = 1'b1;
    void'($urandom(32'hB319));
    port_pd = NP'($urandom);
    strap_in = 8'($urandom);
    node_mac = 48'({$urandom, $urandom}) & 48'h7E7E7E7E7E7E;
    repeat (4) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    tick(2);
    check(mode_sel, PMWC_MODE_NORM);
    check({pll_en, host_if_en, smi_en}, 3'h7);
    check({power_event_out_n, interrupt_out_n}, exp_route(1'b0, 1'b0));
    for (int i = 0; i < 4; i++) begin
      port_pd = NP'($urandom);
      tick(2);
      check({phy_en, mac_en}, {NP'(~port_pd), NP'(~port_pd)});
    end
    // Clock enable low freezes all state: a write is not taken
    clk_en = 1'b0;
    wr(PMWC_MODE_SOFT);
    clk_en = 1'b1;
    check({mode_sel, pll_en, smi_en}, {PMWC_MODE_NORM, 2'h3});
    wr(2'h3);
    check(mode_sel, PMWC_MODE_NORM);
    // Energy-detect: timeout, pulses, short and long energy
    idle_timeout = 24'(3 + $urandom_range(7));
    wr(PMWC_MODE_ENERGY_DETECT_POWER_DOWN);
    check(mode_sel, PMWC_MODE_ENERGY_DETECT_POWER_DOWN);
    n = 0;
    while (pll_en && n < 100) begin
      tick(1);
      n++;
    end
    check(n >= idle_timeout - 1 && n <= idle_timeout + 3, 1'b1);
    check({pll_en, host_if_en, smi_en, mac_en, phy_ed_only}, {8'h0, NP'(~port_pd)});
    n = 0;
    repeat (4 * PER) begin
      n += link_pulse;
      tick(1);
    end
    check(n, 4);
    wake_energy_en = 1'b1;
    cable_energy = NP'(1 << $urandom_range(NP - 1));
    tick(2);
    cable_energy = '0;
    tick(2);
    check(pll_en, 1'b0);
    cable_energy = NP'(1 << $urandom_range(NP - 1));
    tick(4);
    check({pll_en, wake_status[0]}, 2'h3);
    check({power_event_out_n, interrupt_out_n}, exp_route(1'b1, 1'b0));
    wr(PMWC_MODE_NORM);
    check(mode_sel, PMWC_MODE_NORM);
    // Clear, then link-up routed to the interrupt pin
    wake_clear = 1'b1;
    tick(1);
    wake_clear = 1'b0;
    wake_to_irq = 1'b1;
    wake_link_en = 1'b1;
    tick(1);
    check({wake_status, power_event_out_n}, 4'h1);
    link_up = NP'(1 << $urandom_range(NP - 1));
    tick(2);
    check(wake_status[1], 1'b1);
    check({power_event_out_n, interrupt_out_n}, exp_route(1'b1, 1'b1));
    wake_clear = 1'b1;
    tick(1);
    wake_clear = 1'b0;
    wake_to_irq = 1'b0;
    wake_pkt_en = 1'b1;
    // Wake packet: not for node, split across frames, then a real one
    add(6, 16);
    lp_u.send_frame(q, 1'b0);
    tick(3);
    check(wake_status[2], 1'b0);
    q = {};
    add(6, 8);
    lp_u.send_frame(q, 1'b1);
    q = {};
    add(0, 8);
    lp_u.send_frame(q, 1'b1);
    tick(3);
    check(wake_status[2], 1'b0);
    q = {};
    repeat (5) q.push_back(8'($urandom) & 8'h7E);
    add(7, 15);
    q.push_back(node_mac[47:40] ^ 8'h80);
    add(6, 16);
    lp_u.send_frame(q, 1'b1);
    tick(3);
    check({wake_status[2], power_event_out_n}, 2'h2);
    // Soft power-down and exit with strap resample
    wr(PMWC_MODE_SOFT);
    check({smi_en, pll_en, host_if_en, mac_en}, {3'h4, NP'(0)});
    strap_in = ~strap_in;
    // Write by hand so the one-cycle reset pulse is sampled from its first cycle
    pwr_ctrl = {PMWC_MODE_NORM, 3'($urandom)};
    pwr_ctrl_we = 1'b1;
    tick(1);
    pwr_ctrl_we = 1'b0;
    n = 0;
    repeat (3) begin
      n += regs_reset;
      tick(1);
    end
    check(n, 1);
    check({strap_cfg, pll_en, mode_sel}, {strap_in, 1'b1, PMWC_MODE_NORM});
    tally_and_finish();
  end
endmodule
